// ### rtl/sdl_map.svh
// Contract
// - Half-duplex open-drain pin, pull low or release
// - Start low, eight data LSB first, stop high
// - Idle after reset until sync 80H arrives
// - Autobaud measures eight low bits in clocks
// - Bit period measurable down to clock/512
// - Nine low bit-times is break, autobaud resets
// - Detect break, framing error, transmit collision
// - On error abort, send four-character break
// - Host break leaves debug mode state alone
// - Serial logic held reset until pin high
// - Debug mode stops CPU instruction fetch
// - Debug mode exits halt, refreshes watchdog
// - Enter debug on breakpoint or strapped pin
// - Leave debug on bit clear or reset
// - Pin low in stop mode starts reset
// - Breakpoint opcode 00H enters debug when enabled
// - Runtime counter counts outside debug, saturates FFFFH
// - Read protection lets writes only set mode bit
`ifndef SDL_MAP_SVH
`define SDL_MAP_SVH

`define SDL_SYNC_CHAR 8'h80
`define SDL_SYNC_LOW_BITS 13'h8
`define SDL_BRK_BITS 13'h9
`define SDL_MIN_RATE_DIV 13'h200
`define SDL_MIN_BP 10'h4
`define SDL_CHAR_BITS 6'ha
`define SDL_ERR_CHARS 6'h4
`define SDL_BRK_OPCODE 8'h00
`define SDL_MODE_BIT 7
`define SDL_RUN_MAX 16'hffff
`define SDL_RUN_RESET 16'h0000

`endif

// ### rtl/sdl_pkg.sv
`default_nettype none
package sdl_pkg;
  typedef enum logic [1:0] {
    AB_WAIT = 2'b00,
    AB_MEAS = 2'b01,
    AB_LOCK = 2'b10,
    AB_STUCK = 2'b11
  } sdl_ab_e;
  typedef enum logic [2:0] {
    LK_IDLE = 3'b000,
    LK_RX = 3'b001,
    LK_TX = 3'b010,
    LK_ERR = 3'b011,
    LK_HOLD = 3'b100
  } sdl_lk_e;
endpackage
`default_nettype wire

// ### rtl/sdl_baud_if.sv
`default_nettype none
interface sdl_baud_if;
  logic abReset;
  logic restart;
  logic locked;
  logic [9:0] bitPeriod;
  logic midTick;
  logic endTick;
  modport gen (input abReset, input restart, output locked, output bitPeriod, output midTick, output endTick);
  modport user (output abReset, output restart, input locked, input bitPeriod, input midTick, input endTick);
endinterface
`default_nettype wire

// ### rtl/sdl_autobaud.sv
`include "sdl_map.svh"
`default_nettype none
module sdl_autobaud
  import sdl_pkg::*;
#(
  parameter logic [12:0] BREAK_SPAN = 13'h1200
) (
  input wire logic sys_clk, // System clock
  input wire logic resetn, // Synchronous reset, active low
  input wire logic pinIn, // Debug pin level
  sdl_baud_if.gen bi // Timing to the link logic
);
  sdl_ab_e abState_ff, nxt_abState;
  logic [12:0] span_ff, nxt_span;
  logic [9:0] bp_ff, nxt_bp;
  logic [9:0] tick_ff, nxt_tick;

  // ********************
  // Measurement
  // ********************
  always_comb begin
    nxt_abState = abState_ff;
    nxt_span = span_ff;
    nxt_bp = bp_ff;
    unique case (abState_ff)
      AB_WAIT: begin
        if (!pinIn) begin
          nxt_span = 13'h1;
          nxt_abState = AB_MEAS;
        end
      end
      AB_MEAS: begin
        if (pinIn) begin
          nxt_bp = 10'(span_ff / `SDL_SYNC_LOW_BITS);
          nxt_abState = (10'(span_ff / `SDL_SYNC_LOW_BITS) >= `SDL_MIN_BP) ? AB_LOCK : AB_WAIT;
        end else if (span_ff >= BREAK_SPAN - 13'h1) begin
          nxt_abState = AB_STUCK;
        end else begin
          nxt_span = span_ff + 13'h1;
        end
      end
      AB_LOCK: begin
      end
      AB_STUCK: begin
        if (pinIn) begin
          nxt_abState = AB_WAIT;
        end
      end
    endcase
    if (bi.abReset) begin
      nxt_abState = AB_STUCK;
    end
  end

  // Bit timer restarts on each start edge so drift never accumulates
  always_comb begin
    nxt_tick = tick_ff + 10'h1;
    if (bi.restart || tick_ff == bp_ff - 10'h1) begin
      nxt_tick = 10'h0;
    end
  end

  assign bi.locked = (abState_ff == AB_LOCK);
  assign bi.bitPeriod = bp_ff;
  assign bi.midTick = bi.locked && (tick_ff == bp_ff / 10'h2);
  assign bi.endTick = bi.locked && (tick_ff == bp_ff - 10'h1);

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      abState_ff <= AB_WAIT;
      span_ff <= 13'h0;
      bp_ff <= 10'h0;
      tick_ff <= 10'h0;
    end else begin
      abState_ff <= nxt_abState;
      span_ff <= nxt_span;
      bp_ff <= nxt_bp;
      tick_ff <= nxt_tick;
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  lock_min_period_a: assert property (bi.locked |-> bp_ff >= `SDL_MIN_BP) else $error("locked below min period");
  meas_to_lock_a: assert property ((abState_ff == AB_MEAS && pinIn && !bi.abReset && span_ff >= 13'h20)
    |=> bi.locked && bp_ff == 10'($past(span_ff) / `SDL_SYNC_LOW_BITS)) else $error("period not taken");
endmodule // sdl_autobaud
`default_nettype wire

// ### rtl/sdl_debug_link.sv
`include "sdl_map.svh"
`default_nettype none
module sdl_debug_link
  import sdl_pkg::*;
#(
  parameter logic [12:0] BREAK_SPAN = 13'(`SDL_MIN_RATE_DIV * `SDL_BRK_BITS)
) (
  input wire logic sys_clk, // System clock, 100 MHz
  input wire logic resetn, // Synchronous reset, active low
  input wire logic dbgPinIn, // Debug pin level
  output logic dbgPinOut, // Debug pin drive value
  output logic dbgPinOe, // Debug pin pulled low when high
  output logic [7:0] rxData, // Received character
  output logic rxValid, // Received character strobe
  input wire logic [7:0] txData, // Character to send
  input wire logic txValid, // Send request
  output logic txReady, // Transmitter accepts
  output logic cmdAbort, // Abort current command
  output logic linkLocked, // Bit rate known
  input wire logic insnDecode, // CPU decoded an opcode
  input wire logic [7:0] insnOpcode, // Decoded opcode
  input wire logic brkEnable, // Breakpoints enabled
  input wire logic ctrlWrite, // Debug control register write
  input wire logic [7:0] ctrlData, // Debug control write data
  input wire logic flashReadProtect, // Read protection option
  input wire logic stopMode, // Device in stop mode
  input wire logic wdtEnable, // Watchdog enabled
  output logic fetchHalt, // Debug mode, CPU fetch stopped
  output logic haltExit, // Leave halt mode pulse
  output logic wdtRefresh, // Watchdog refresh
  output logic brkIgnored, // Breakpoint run as no-op
  output logic sysResetReq, // System reset request
  output logic [15:0] runtimeCount // Runtime counter
);
  localparam logic [5:0] ERR_BITS = 6'(`SDL_ERR_CHARS * `SDL_CHAR_BITS);
  localparam logic [5:0] STOP_IDX = `SDL_CHAR_BITS - 6'h1;

  sdl_baud_if bi ();

  sdl_autobaud #(
    .BREAK_SPAN(BREAK_SPAN)
  ) u_autobaud (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .pinIn(dbgPinIn),
    .bi(bi.gen)
  );

  // ********************
  // Serial link
  // ********************
  sdl_lk_e lkState_ff, nxt_lkState;
  logic [5:0] bitIdx_ff, nxt_bitIdx;
  logic [9:0] shift_ff, nxt_shift;
  logic [7:0] rxData_ff, nxt_rxData;
  logic rxValid_ff, nxt_rxValid;
  logic abort_ff, nxt_abort;
  logic drvLow_ff, nxt_drvLow;
  logic [12:0] lowCnt_ff, nxt_lowCnt;
  logic [12:0] brkLimit;
  logic hostBreak;
  logic linkErr;
  logic restartReq;

  assign brkLimit = 13'(13'(bi.bitPeriod) * `SDL_BRK_BITS);
  // Only the far side's low time counts; our own zeros are not a break
  assign hostBreak = bi.locked && (lowCnt_ff >= brkLimit)
    && (lkState_ff == LK_IDLE || lkState_ff == LK_RX || lkState_ff == LK_TX);

  always_comb begin
    nxt_lowCnt = 13'h0;
    if (!dbgPinIn && !drvLow_ff && lowCnt_ff != 13'h1fff) begin
      nxt_lowCnt = lowCnt_ff + 13'h1;
    end else if (!dbgPinIn && !drvLow_ff) begin
      nxt_lowCnt = lowCnt_ff;
    end
  end

  always_comb begin
    nxt_lkState = lkState_ff;
    nxt_bitIdx = bitIdx_ff;
    nxt_shift = shift_ff;
    nxt_rxData = rxData_ff;
    nxt_rxValid = 1'b0;
    nxt_abort = 1'b0;
    nxt_drvLow = drvLow_ff;
    linkErr = 1'b0;
    restartReq = 1'b0;
    unique case (lkState_ff)
      LK_IDLE: begin
        // Receive takes priority so the pin is never driven over a host start bit
        if (bi.locked && !dbgPinIn) begin
          restartReq = 1'b1;
          nxt_bitIdx = 6'h0;
          nxt_lkState = LK_RX;
        end else if (bi.locked && txValid) begin
          restartReq = 1'b1;
          nxt_shift = {1'b1, txData, 1'b0};
          nxt_drvLow = 1'b1;
          nxt_bitIdx = 6'h0;
          nxt_lkState = LK_TX;
        end
      end
      LK_RX: begin
        if (bi.midTick) begin
          nxt_bitIdx = bitIdx_ff + 6'h1;
          if (bitIdx_ff == 6'h0) begin
            if (dbgPinIn) begin
              nxt_lkState = LK_IDLE;
            end
          end else if (bitIdx_ff == STOP_IDX) begin
            nxt_lkState = LK_IDLE;
            if (!dbgPinIn) begin
              linkErr = 1'b1;
            end else begin
              nxt_rxData = shift_ff[7:0];
              nxt_rxValid = 1'b1;
            end
          end else begin
            nxt_shift = {2'b00, dbgPinIn, shift_ff[7:1]};
          end
        end
      end
      LK_TX: begin
        if (bi.midTick && !drvLow_ff && !dbgPinIn) begin
          linkErr = 1'b1;
        end else if (bi.endTick) begin
          if (bitIdx_ff == STOP_IDX) begin
            nxt_drvLow = 1'b0;
            nxt_lkState = LK_IDLE;
          end else begin
            nxt_shift = {1'b0, shift_ff[9:1]};
            nxt_drvLow = !shift_ff[1];
            nxt_bitIdx = bitIdx_ff + 6'h1;
          end
        end
      end
      LK_ERR: begin
        if (bi.endTick) begin
          if (bitIdx_ff == ERR_BITS - 6'h1) begin
            nxt_drvLow = 1'b0;
            nxt_lkState = LK_HOLD;
          end else begin
            nxt_bitIdx = bitIdx_ff + 6'h1;
          end
        end
      end
      LK_HOLD: begin
        if (dbgPinIn) begin
          nxt_lkState = LK_IDLE;
        end
      end
      default: begin
        nxt_drvLow = 1'b0;
        nxt_lkState = LK_IDLE;
      end
    endcase
    if (hostBreak) begin
      linkErr = 1'b1;
    end
    // Reply break uses the old rate, so the autobaud is reset only afterwards
    if (linkErr) begin
      restartReq = 1'b1;
      nxt_abort = 1'b1;
      nxt_rxValid = 1'b0;
      nxt_drvLow = 1'b1;
      nxt_bitIdx = 6'h0;
      nxt_lkState = LK_ERR;
    end
  end

  assign bi.restart = restartReq;
  assign bi.abReset = (lkState_ff == LK_HOLD);
  assign txReady = (lkState_ff == LK_IDLE) && bi.locked && dbgPinIn;
  assign linkLocked = bi.locked;
  assign dbgPinOut = 1'b0;
  assign dbgPinOe = drvLow_ff;
  assign rxData = rxData_ff;
  assign rxValid = rxValid_ff;
  assign cmdAbort = abort_ff;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      lkState_ff <= LK_IDLE;
      bitIdx_ff <= 6'h0;
      shift_ff <= 10'h0;
      rxData_ff <= 8'h0;
      rxValid_ff <= 1'b0;
      abort_ff <= 1'b0;
      drvLow_ff <= 1'b0;
      lowCnt_ff <= 13'h0;
    end else begin
      lkState_ff <= nxt_lkState;
      bitIdx_ff <= nxt_bitIdx;
      shift_ff <= nxt_shift;
      rxData_ff <= nxt_rxData;
      rxValid_ff <= nxt_rxValid;
      abort_ff <= nxt_abort;
      drvLow_ff <= nxt_drvLow;
      lowCnt_ff <= nxt_lowCnt;
    end
  end

  // ********************
  // Debug mode
  // ********************
  logic debugMode_ff, nxt_debugMode;
  logic strapPin_ff;
  logic inReset_ff;
  logic haltExit_ff, nxt_haltExit;
  logic wdtRefresh_ff, nxt_wdtRefresh;
  logic brkIgnored_ff, nxt_brkIgnored;
  logic sysResetReq_ff, nxt_sysResetReq;
  logic [15:0] runCnt_ff, nxt_runCnt;
  logic brkHit;

  assign brkHit = insnDecode && (insnOpcode == `SDL_BRK_OPCODE);

  // Serial errors never reach this state, so a break keeps debug mode
  always_comb begin
    nxt_debugMode = debugMode_ff;
    if (ctrlWrite && !ctrlData[`SDL_MODE_BIT] && !flashReadProtect) begin
      nxt_debugMode = 1'b0;
    end
    if (ctrlWrite && ctrlData[`SDL_MODE_BIT]) begin
      nxt_debugMode = 1'b1;
    end
    if (brkHit && brkEnable) begin
      nxt_debugMode = 1'b1;
    end
    if (inReset_ff && !strapPin_ff) begin
      nxt_debugMode = 1'b1;
    end
    nxt_haltExit = nxt_debugMode && !debugMode_ff;
    nxt_wdtRefresh = debugMode_ff && wdtEnable;
    nxt_brkIgnored = brkHit && !brkEnable;
    nxt_sysResetReq = stopMode && !dbgPinIn;
    nxt_runCnt = runCnt_ff;
    if (debugMode_ff && !nxt_debugMode) begin
      nxt_runCnt = `SDL_RUN_RESET;
    end else if (!debugMode_ff && !nxt_debugMode && runCnt_ff != `SDL_RUN_MAX) begin
      nxt_runCnt = runCnt_ff + 16'h1;
    end
  end

  // Pin level is sampled every cycle, so the value held at release is the last reset cycle
  always_ff @(posedge sys_clk) begin
    strapPin_ff <= dbgPinIn;
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      debugMode_ff <= 1'b0;
      inReset_ff <= 1'b1;
      haltExit_ff <= 1'b0;
      wdtRefresh_ff <= 1'b0;
      brkIgnored_ff <= 1'b0;
      sysResetReq_ff <= 1'b0;
      runCnt_ff <= `SDL_RUN_RESET;
    end else begin
      debugMode_ff <= nxt_debugMode;
      inReset_ff <= 1'b0;
      haltExit_ff <= nxt_haltExit;
      wdtRefresh_ff <= nxt_wdtRefresh;
      brkIgnored_ff <= nxt_brkIgnored;
      sysResetReq_ff <= nxt_sysResetReq;
      runCnt_ff <= nxt_runCnt;
    end
  end

  assign fetchHalt = debugMode_ff;
  assign haltExit = haltExit_ff;
  assign wdtRefresh = wdtRefresh_ff;
  assign brkIgnored = brkIgnored_ff;
  assign sysResetReq = sysResetReq_ff;
  assign runtimeCount = runCnt_ff;

  // ********************
  // Checks
  // ********************
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  sequence holdRelease;
    lkState_ff == LK_HOLD ##0 dbgPinIn;
  endsequence
  sequence txLaunch;
    lkState_ff == LK_IDLE && bi.locked && dbgPinIn && txValid && !hostBreak;
  endsequence

  rx_no_drive_a: assert property (lkState_ff == LK_RX |-> !dbgPinOe) else $error("drove pin while receiving");
  tx_start_low_a: assert property (txLaunch |=> dbgPinOe && lkState_ff == LK_TX) else $error("no start bit");
  tx_stop_high_a: assert property (lkState_ff == LK_TX && bitIdx_ff == STOP_IDX |-> !dbgPinOe)
    else $error("stop bit driven low");
  host_break_err_a: assert property (hostBreak |=> lkState_ff == LK_ERR && cmdAbort && dbgPinOe)
    else $error("break not answered");
  frame_err_a: assert property (lkState_ff == LK_RX && bi.midTick && bitIdx_ff == STOP_IDX && !dbgPinIn
    |=> lkState_ff == LK_ERR && !rxValid) else $error("framing error missed");
  tx_collision_a: assert property (lkState_ff == LK_TX && bi.midTick && !dbgPinOe && !dbgPinIn
    |=> lkState_ff == LK_ERR) else $error("collision missed");
  err_break_out_a: assert property (lkState_ff == LK_ERR |-> dbgPinOe && !bi.abReset)
    else $error("reply break not driven");
  hold_release_a: assert property (holdRelease |=> lkState_ff == LK_IDLE && !bi.locked)
    else $error("hold not released");
  brk_enter_a: assert property (brkHit && brkEnable |=> fetchHalt ##1 (fetchHalt || $past(ctrlWrite)))
    else $error("breakpoint did not halt");
  brk_nop_a: assert property (brkHit && !brkEnable && !debugMode_ff && !ctrlWrite && !inReset_ff
    |=> !fetchHalt && brkIgnored) else $error("disabled breakpoint halted");
  frp_keep_a: assert property (debugMode_ff && flashReadProtect |=> fetchHalt) else $error("protected mode cleared");
  strap_entry_a: assert property (inReset_ff && !strapPin_ff |=> fetchHalt) else $error("strap entry missed");
  run_frozen_a: assert property (debugMode_ff && nxt_debugMode |=> runtimeCount == $past(runtimeCount))
    else $error("counter moved in debug");
  run_restart_a: assert property (debugMode_ff && !nxt_debugMode |=> runtimeCount == 16'h0 ##1 runtimeCount == 16'h1
    || fetchHalt) else $error("counter not restarted");
  stop_wake_a: assert property (stopMode && !dbgPinIn |=> sysResetReq) else $error("stop wake missed");
  wdt_feed_a: assert property (debugMode_ff && wdtEnable |=> wdtRefresh) else $error("watchdog not fed");
endmodule // sdl_debug_link
`default_nettype wire

// ### tb/sdl_host_model.sv
`default_nettype none
module sdl_host_model (
  input wire logic sys_clk, // System clock
  input wire logic pinIn, // Wire level
  output logic pullLow, // Host pulls pin low
  output logic [7:0] gotByte, // Byte heard from device
  output logic gotValid // One-cycle strobe
);
  timeunit 1ns;
  timeprecision 1ns;
  int unsigned bitCycles = 8;
  logic listen = 1'b0;
  logic [7:0] sh;
  initial begin
    pullLow = 1'b0;
    gotByte = 8'h00;
    gotValid = 1'b0;
  end
  // ****************
  // Host transmit
  // ****************
  // Open drain: the host only pulls low or lets go
  task automatic sendFrame(input logic [7:0] b, input logic stopBit);
    logic [9:0] f;
    f = {stopBit, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      pullLow = ~f[i];
      repeat (bitCycles) @(negedge sys_clk);
    end
    // A good stop bit already released the pin; back-to-back frames must not retoggle it
    if (!stopBit) pullLow = 1'b0;
  endtask
  task automatic sendBreak(input int n);
    pullLow = 1'b1;
    repeat (n) @(negedge sys_clk);
    pullLow = 1'b0;
  endtask
  // ****************
  // Host receive
  // ****************
  // Off while the host talks, or it would hear itself
  initial begin
    forever begin
      @(negedge sys_clk);
      gotValid = 1'b0;
      if (listen && !pullLow && !pinIn) begin
        repeat (bitCycles / 2) @(negedge sys_clk);
        for (int i = 0; i < 8; i++) begin
          repeat (bitCycles) @(negedge sys_clk);
          sh[i] = pinIn;
        end
        repeat (bitCycles) @(negedge sys_clk);
        gotByte = sh;
        gotValid = pinIn;
      end
    end
  end
endmodule // sdl_host_model
`default_nettype wire

// ### tb/test_single_pin_debug_link.sv
`default_nettype none
module test_single_pin_debug_link;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int P = 8;
  logic sys_clk, resetn, dbgPinOut, dbgPinOe, rxValid, txValid, txReady, cmdAbort, linkLocked, insnDecode;
  logic brkEnable, ctrlWrite, flashReadProtect, stopMode, wdtEnable, fetchHalt, haltExit, wdtRefresh;
  logic brkIgnored, sysResetReq, hostPull, gotValid;
  logic [7:0] rxData, txData, insnOpcode, ctrlData, gotByte, b;
  logic [15:0] runtimeCount, r, oeRun, oeLast;
  wire logic dbgPin;
  logic [7:0] rxQ[$];
  logic [7:0] hostQ[$];
  logic abortQ[$];
  int miscompares = 0;
  int checks_done = 0;
  int cyc = 0;
  int leaveCyc, brkIgCnt, haltExitCnt;
  // Pull-up wins when nobody pulls
  assign dbgPin = ~(dbgPinOe | hostPull);
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  sdl_debug_link #(.BREAK_SPAN(13'h100)) dut (
    .sys_clk(sys_clk), .resetn(resetn), .dbgPinIn(dbgPin), .dbgPinOut(dbgPinOut), .dbgPinOe(dbgPinOe),
    .rxData(rxData), .rxValid(rxValid), .txData(txData), .txValid(txValid), .txReady(txReady),
    .cmdAbort(cmdAbort), .linkLocked(linkLocked), .insnDecode(insnDecode), .insnOpcode(insnOpcode),
    .brkEnable(brkEnable), .ctrlWrite(ctrlWrite), .ctrlData(ctrlData), .flashReadProtect(flashReadProtect),
    .stopMode(stopMode), .wdtEnable(wdtEnable), .fetchHalt(fetchHalt), .haltExit(haltExit),
    .wdtRefresh(wdtRefresh), .brkIgnored(brkIgnored), .sysResetReq(sysResetReq), .runtimeCount(runtimeCount));
  sdl_host_model hostM (.sys_clk(sys_clk), .pinIn(dbgPin), .pullLow(hostPull), .gotByte(gotByte),
    .gotValid(gotValid));
  // ****************
  // Compare and report
  // ****************
  task automatic checkByte(input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  task automatic checkWord(input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  task automatic checkBit(input logic e, input logic g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  task automatic results();
    $display("Checks done %0d, miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Device outputs settle after the rising edge, host outputs after the falling one
  always @(negedge sys_clk) begin
    if (rxValid === 1'b1) checkByte(rxQ.size() > 0 ? rxQ.pop_front() : 8'hxx, rxData);
    if (cmdAbort === 1'b1) checkBit(abortQ.size() > 0 ? abortQ.pop_front() : 1'bx, 1'b1);
    if (brkIgnored === 1'b1) brkIgCnt++;
    if (haltExit === 1'b1) haltExitCnt++;
    if (dbgPinOe === 1'b1) oeRun = oeRun + 16'h1;
    else begin
      if (oeRun != 16'h0) oeLast = oeRun;
      oeRun = 16'h0;
    end
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (gotValid === 1'b1) checkByte(hostQ.size() > 0 ? hostQ.pop_front() : 8'hxx, gotByte);
  end
  // ****************
  // Drivers
  // ****************
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic ctrl(input logic [7:0] d);
    ctrlData = d;
    ctrlWrite = 1'b1;
    tick(1);
    ctrlWrite = 1'b0;
    tick(2);
  endtask
  task automatic decode(input logic [7:0] op);
    insnOpcode = op;
    insnDecode = 1'b1;
    tick(1);
    insnDecode = 1'b0;
    tick(3);
  endtask
  task automatic rxSend(input int n);
    logic [7:0] v;
    for (int i = 0; i < n; i++) begin
      // All-zero byte is nine low bit-times, which the link rightly takes as a break
      v = 8'($urandom_range(255, 1));
      rxQ.push_back(v);
      hostM.sendFrame(v, 1'b1);
    end
  endtask
  task automatic txSend(input logic [7:0] v, input logic keep);
    int n;
    n = 0;
    if (keep) hostQ.push_back(v);
    txData = v;
    txValid = 1'b1;
    while (txReady !== 1'b1 && n < 4000) begin
      tick(1);
      n++;
    end
    tick(1);
    txValid = 1'b0;
    checkBit(1'b0, txReady);
    tick(1);
  endtask
  task automatic doSync(input int p);
    hostM.bitCycles = p;
    tick(4);
    hostM.sendFrame(8'h80, 1'b1);
    tick(2);
    checkBit(1'b1, linkLocked);
  endtask
  task automatic errReply(input int p);
    int n;
    n = 0;
    while (dbgPin !== 1'b1 && n < 2000) begin
      tick(1);
      n++;
    end
    tick(2);
    checkWord(16'(40 * p), oeLast);
    checkBit(1'b0, linkLocked);
  endtask
  // ****************
  // Main sequence
  // ****************
  initial begin
    {resetn, txValid, insnDecode, brkEnable, ctrlWrite, flashReadProtect, stopMode, wdtEnable} = 8'h00;
    txData = 8'h00;
    insnOpcode = 8'h00;
    ctrlData = 8'h00;
    oeRun = 16'h0;
    oeLast = 16'h0;
    brkIgCnt = 0;
    haltExitCnt = 0;
    b = 8'($urandom(68));
    #1;
    hostM.sendBreak(8);
    resetn = 1'b1;
    checkBit(1'b0, dbgPinOe);
    checkBit(1'b0, dbgPinOut);
    checkBit(1'b0, linkLocked);
    tick(3);
    checkBit(1'b1, fetchHalt);
    checkWord(16'h0, runtimeCount);
    wdtEnable = 1'b1;
    tick(2);
    checkBit(1'b1, wdtRefresh);
    wdtEnable = b[0];
    tick(2);
    checkBit(b[0], wdtRefresh);
    ctrl(8'h00);
    leaveCyc = cyc;
    checkBit(1'b0, fetchHalt);
    r = runtimeCount;
    tick(50);
    checkWord(r + 16'h32, runtimeCount);
    hostM.sendBreak(300);
    doSync(P);
    rxSend(4);
    hostM.listen = 1'b1;
    for (int i = 0; i < 3; i++) txSend(8'($urandom), 1'b1);
    tick(12 * P);
    hostM.listen = 1'b0;
    abortQ.push_back(1'b1);
    hostM.sendFrame(8'($urandom), 1'b0);
    errReply(P);
    doSync(2 * P);
    rxSend(2);
    abortQ.push_back(1'b1);
    txSend(8'hff, 1'b0);
    tick(2 * P + 2);
    hostM.sendBreak(2 * P - 3);
    errReply(2 * P);
    doSync(P);
    while (cyc < leaveCyc + 65600) tick(1);
    checkWord(16'hffff, runtimeCount);
    ctrl(8'h80);
    abortQ.push_back(1'b1);
    hostM.sendBreak(9 * P + 4);
    errReply(P);
    checkBit(1'b1, fetchHalt);
    ctrl(8'h00);
    decode(8'h00);
    checkBit(1'b0, fetchHalt);
    checkWord(16'h1, 16'(brkIgCnt));
    brkEnable = 1'b1;
    decode(8'($urandom_range(255, 1)));
    checkBit(1'b0, fetchHalt);
    haltExitCnt = 0;
    wdtEnable = 1'b1;
    decode(8'h00);
    checkBit(1'b1, fetchHalt);
    checkWord(16'(haltExitCnt), 16'h1);
    checkBit(1'b1, wdtRefresh);
    r = runtimeCount;
    tick(20);
    checkWord(r, runtimeCount);
    wdtEnable = 1'b0;
    tick(2);
    checkBit(1'b0, wdtRefresh);
    flashReadProtect = 1'b1;
    ctrl(8'h00);
    checkBit(1'b1, fetchHalt);
    flashReadProtect = 1'b0;
    ctrl(8'h00);
    checkBit(1'b0, fetchHalt);
    ctrl(8'h80);
    resetn = 1'b0;
    tick(2);
    resetn = 1'b1;
    tick(3);
    checkBit(1'b0, fetchHalt);
    stopMode = b[1];
    hostM.sendBreak(3);
    checkBit(b[1], sysResetReq);
    tick(3);
    stopMode = 1'b1;
    hostM.sendBreak(3);
    checkBit(1'b1, sysResetReq);
    tick(3);
    checkBit(1'b0, sysResetReq);
    stopMode = 1'b0;
    checkWord(16'(rxQ.size() + hostQ.size() + abortQ.size()), 16'h0);
    results();
  end
  // Stall guard, well beyond the saturation wait
  initial begin
    repeat (95000) @(posedge sys_clk);
    miscompares++;
    results();
  end
endmodule // test_single_pin_debug_link
`default_nettype wire
